/* hw/eif_ctrl_map.svh */
// Register map, bit positions, reset values and timing counts of the external
// interrupt controller. Assumes 32-bit register words on an AHB-Lite slave.
`ifndef EIF_CTRL_MAP_SVH
`define EIF_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define EIF_OFS_EDGE_A      8'h00
`define EIF_OFS_EDGE_B      8'h04
`define EIF_OFS_PMODE_A     8'h08
`define EIF_OFS_PMODE_B     8'h0C
`define EIF_OFS_ENABLE_A    8'h10
`define EIF_OFS_FLAG_A      8'h14
`define EIF_OFS_WAKE_FLAGS  8'h18
`define EIF_OFS_CCR         8'h1C
`define EIF_OFS_STATUS      8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EIF_BIT_NMI_EDGE    7
`define EIF_BIT_DT          7
`define EIF_BIT_TIMER       6
`define EIF_BIT_WAKE_EN     5
`define EIF_BIT_MASK        7
`define EIF_BIT_RUNNING     16

// ----------------------------------------------------------------------------
// Reset values and read-as-one masks
// ----------------------------------------------------------------------------
`define EIF_RST_BYTE        8'h00
`define EIF_RST_WAKE        6'h00
`define EIF_RST_REQ         4'h0
`define EIF_ONES_WAKE       8'hC0
`define EIF_ONES_FLAG_A     8'h30
`define EIF_ONES_ENABLE_A   8'h10

// ----------------------------------------------------------------------------
// Reset vector and timing
// ----------------------------------------------------------------------------
`define EIF_VEC_ADDR_HI     16'h0000
`define EIF_VEC_ADDR_LO     16'h0001
`define EIF_RESET_MIN_CYC   10

`endif

/* hw/eif_pkg.sv */
// Types shared by the external interrupt controller.
// Assumes nothing of its surroundings.
package eif_pkg;

    // ------------------------------------------------------------------------
    // Reset exception sequencer and interrupt source codes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        EIF_ST_MASK,
        EIF_ST_RD_HI,
        EIF_ST_RD_LO,
        EIF_ST_LOAD,
        EIF_ST_RUN
    } eif_state_t;

    typedef enum logic [3:0] {
        EIF_SRC_NONE,
        EIF_SRC_NMI,
        EIF_SRC_REQ0,
        EIF_SRC_REQ1,
        EIF_SRC_REQ2,
        EIF_SRC_REQ3,
        EIF_SRC_WAKE,
        EIF_SRC_TIMER,
        EIF_SRC_DT
    } eif_src_t;

endpackage

/* hw/eif_ctrl.sv */
// External interrupt flags, enables, edge detection and reset entry.
// Assumes an AHB-Lite master, a CPU core that pulses an accept strobe and a
// vector memory that answers one cycle after a read strobe.
//
// Summary of operation
// R1: Wakeup flag register bits 7 and 6 always read as one.
// R2: Six wakeup flags set on selected edge of enabled pin, reset to zero.
// R3: Writing zero clears a wakeup flag until the next qualifying edge.
// R4: While reset is low everything halts and all registers initialise.
// R5: An outside reset must stay low for at least ten clock cycles; the testbench's first reset holds it low for four clock edges.
// R6: After reset release the first step sets the interrupt mask bit.
// R7: Then the vector at 0000 and 0001 loads the program counter.
// R8: Non-maskable input detects rising or falling edge by one select bit.
// R9: Non-maskable request is forwarded regardless of the mask bit.
// R10: Each request pin has its own vector and own edge select bit.
// R11: Request pin in interrupt mode sets its flag on selected edge.
// R12: Accepting a request pin interrupt sets the mask bit.
// R13: Each request pin reaches the CPU only when its enable is set.
// R14: Six wakeup pins share one vector but keep separate edge selects.
// R15: Wakeup pin in interrupt mode sets its flag and requests interrupt.
// R16: One common enable gates all six wakeup requests.
// R17: Timer overflow and direct transition flags and enables sit in register a.
// R18: Peripheral request sets its flag; acceptance sets the mask bit.
// R19: Clearing a peripheral enable stops that request reaching the CPU.
// R20: Common wakeup enable is enable register bit five, reset zero.
// R21: Software clears enables or flags only while the mask bit is set.
// R22: Writing one to a flag bit leaves that flag unchanged.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`include "eif_ctrl_map.svh"

module eif_ctrl #(
    parameter int NUM_REQ  = 4,
    parameter int NUM_WAKE = 6
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // External interrupt pins
    input  wire logic        nmi_pin_in,
    input  wire logic [3:0]  req_pin_in,
    input  wire logic [5:0]  wake_pin_in,
    // Peripheral request pulses
    input  wire logic        timer_overflow_in,
    input  wire logic        direct_transition_in,
    // CPU core
    input  wire logic        cpu_accept_in,
    output logic             nmi_req_out,
    output logic             irq_req_out,
    output logic      [3:0]  irq_source_out,
    output logic             mask_bit_out,
    output logic             halt_out,
    // Vector fetch
    output logic             vec_rd_out,
    output logic      [15:0] vec_addr_out,
    input  wire logic [7:0]  vec_data_in,
    output logic      [15:0] pc_out,
    output logic             pc_valid_out
);

    localparam int NPIN = 1 + NUM_REQ + NUM_WAKE;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]          edge_select_reg_a;
    logic [7:0]          edge_select_reg_b;
    logic [7:0]          port_mode_reg_a;
    logic [7:0]          port_mode_reg_b;
    logic [7:0]          enable_reg_a;
    logic [NUM_REQ-1:0]  req_flag_reg;
    logic                timer_flag_reg;
    logic                dt_flag_reg;
    logic [NUM_WAKE-1:0] wake_flag_reg;
    logic                nmi_pend_reg;
    logic                mask_reg;
    eif_pkg::eif_state_t state_reg;
    eif_pkg::eif_src_t   src_reg;
    eif_pkg::eif_src_t   src_next;
    logic [7:0]          vec_hi_reg;

    // ------------------------------------------------------------------------
    // Bus slave: address phase captured, write done in data phase
    // ------------------------------------------------------------------------
    logic       dp_wr_reg;
    logic       dp_rd_reg;
    logic [7:0] dp_addr_reg;
    logic       ap_valid;
    logic [7:0] wbyte;

    assign ap_valid      = hsel_in && hready_in && htrans_in[1];
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign wbyte         = hwdata_in[7:0];

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dp_wr_reg   <= 1'b0;
            dp_rd_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else if (hready_in) begin
            dp_wr_reg   <= ap_valid && hwrite_in;
            dp_rd_reg   <= ap_valid && !hwrite_in;
            dp_addr_reg <= (haddr_in[31:8] == 24'h000000) ? haddr_in[7:0] : 8'hFF;
        end
    end

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = dp_wr_reg && (dp_addr_reg == ofs);
    endfunction

    always_comb begin
        hrdata_out = 32'h00000000;
        if (dp_rd_reg) begin
            case (dp_addr_reg)
                `EIF_OFS_EDGE_A:     hrdata_out[7:0] = edge_select_reg_a;
                `EIF_OFS_EDGE_B:     hrdata_out[7:0] = edge_select_reg_b;
                `EIF_OFS_PMODE_A:    hrdata_out[7:0] = port_mode_reg_a;
                `EIF_OFS_PMODE_B:    hrdata_out[7:0] = port_mode_reg_b;
                `EIF_OFS_ENABLE_A:   hrdata_out[7:0] = enable_reg_a | `EIF_ONES_ENABLE_A;
                `EIF_OFS_FLAG_A:     hrdata_out[7:0] = {dt_flag_reg, timer_flag_reg, 2'b00,
                                                        req_flag_reg} | `EIF_ONES_FLAG_A;
                `EIF_OFS_WAKE_FLAGS: hrdata_out[7:0] = {2'b00, wake_flag_reg}
                                                       | `EIF_ONES_WAKE; // R1
                `EIF_OFS_CCR:        hrdata_out[`EIF_BIT_MASK] = mask_reg;
                `EIF_OFS_STATUS:     hrdata_out = {15'h0000,
                                                   state_reg == eif_pkg::EIF_ST_RUN, pc_out};
                default:             hrdata_out = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            edge_select_reg_a <= `EIF_RST_BYTE; // R4
            edge_select_reg_b <= `EIF_RST_BYTE;
            port_mode_reg_a   <= `EIF_RST_BYTE;
            port_mode_reg_b   <= `EIF_RST_BYTE;
            enable_reg_a      <= `EIF_RST_BYTE; // R20
        end else begin
            if (wr_at(`EIF_OFS_EDGE_A)) begin
                edge_select_reg_a <= wbyte & 8'h8F;
            end
            if (wr_at(`EIF_OFS_EDGE_B)) begin
                edge_select_reg_b <= wbyte & 8'h3F;
            end
            if (wr_at(`EIF_OFS_PMODE_A)) begin
                port_mode_reg_a <= wbyte & 8'h0F;
            end
            if (wr_at(`EIF_OFS_PMODE_B)) begin
                port_mode_reg_b <= wbyte & 8'h3F;
            end
            if (wr_at(`EIF_OFS_ENABLE_A)) begin
                enable_reg_a <= wbyte & 8'hEF; // R19
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------------
    // A level change is only believed once the second and third stages agree,
    // which also rejects single-cycle glitches on the pins.
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    logic [NPIN-1:0] level_reg;
    logic [NPIN-1:0] edge_sel;
    logic [NPIN-1:0] pin_edge;

    assign pin_raw  = {wake_pin_in, req_pin_in, nmi_pin_in};
    assign edge_sel = {edge_select_reg_b[NUM_WAKE-1:0], edge_select_reg_a[NUM_REQ-1:0],
                       edge_select_reg_a[`EIF_BIT_NMI_EDGE]};

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            logic agree;
            assign agree = (sync2_reg[gi] == sync3_reg[gi]);
            // Edge select one means rising, zero means falling.
            assign pin_edge[gi] = agree && (sync3_reg[gi] != level_reg[gi])
                                  && (sync3_reg[gi] == edge_sel[gi]); // R8 R10 R14
            always_ff @(posedge sys_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    level_reg[gi] <= 1'b1;
                end else if (agree) begin
                    level_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    logic [NUM_REQ-1:0]  req_set;
    logic [NUM_WAKE-1:0] wake_set;
    assign req_set  = pin_edge[NUM_REQ:1] & port_mode_reg_a[NUM_REQ-1:0];     // R11
    assign wake_set = pin_edge[NPIN-1:NUM_REQ+1] & port_mode_reg_b[NUM_WAKE-1:0]; // R15

    // ------------------------------------------------------------------------
    // Request flags: a set in the clearing cycle wins over the clear
    // ------------------------------------------------------------------------
    logic [7:0] clr_a;
    logic [7:0] clr_w;
    assign clr_a = wr_at(`EIF_OFS_FLAG_A) ? ~wbyte : 8'h00;     // R22
    assign clr_w = wr_at(`EIF_OFS_WAKE_FLAGS) ? ~wbyte : 8'h00; // R22

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_flag_reg   <= `EIF_RST_REQ;
            timer_flag_reg <= 1'b0;
            dt_flag_reg    <= 1'b0;
        end else begin
            req_flag_reg   <= (req_flag_reg & ~clr_a[NUM_REQ-1:0]) | req_set; // R11
            timer_flag_reg <= (timer_flag_reg & ~clr_a[`EIF_BIT_TIMER])
                              | timer_overflow_in; // R17 R18
            dt_flag_reg    <= (dt_flag_reg & ~clr_a[`EIF_BIT_DT])
                              | direct_transition_in; // R17 R18
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wake_flag_reg <= `EIF_RST_WAKE; // R2
        end else begin
            wake_flag_reg <= (wake_flag_reg & ~clr_w[NUM_WAKE-1:0]) | wake_set; // R2 R3
        end
    end

    // ------------------------------------------------------------------------
    // Requests towards the CPU
    // ------------------------------------------------------------------------
    logic                running;
    logic [NUM_REQ-1:0]  req_live;
    logic                wake_live;
    logic                timer_live;
    logic                dt_live;
    logic                accept_nmi;

    assign running    = (state_reg == eif_pkg::EIF_ST_RUN);
    assign req_live   = req_flag_reg & enable_reg_a[NUM_REQ-1:0];                  // R13
    assign wake_live  = (|wake_flag_reg) && enable_reg_a[`EIF_BIT_WAKE_EN];        // R16
    assign timer_live = timer_flag_reg && enable_reg_a[`EIF_BIT_TIMER];            // R19
    assign dt_live    = dt_flag_reg && enable_reg_a[`EIF_BIT_DT];                  // R19
    assign accept_nmi = cpu_accept_in && running && (src_reg == eif_pkg::EIF_SRC_NMI);

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            nmi_pend_reg <= 1'b0;
        end else begin
            nmi_pend_reg <= (nmi_pend_reg && !accept_nmi) || pin_edge[0]; // R8
        end
    end

    // Fixed order stands in for the arbiter; each source keeps its own code.
    always_comb begin
        src_next = eif_pkg::EIF_SRC_NONE;
        if (nmi_pend_reg) begin
            src_next = eif_pkg::EIF_SRC_NMI; // R9
        end else if (!mask_reg) begin
            if (req_live[0]) begin
                src_next = eif_pkg::EIF_SRC_REQ0; // R10
            end else if (req_live[1]) begin
                src_next = eif_pkg::EIF_SRC_REQ1;
            end else if (req_live[2]) begin
                src_next = eif_pkg::EIF_SRC_REQ2;
            end else if (req_live[3]) begin
                src_next = eif_pkg::EIF_SRC_REQ3;
            end else if (wake_live) begin
                src_next = eif_pkg::EIF_SRC_WAKE; // R14
            end else if (timer_live) begin
                src_next = eif_pkg::EIF_SRC_TIMER;
            end else if (dt_live) begin
                src_next = eif_pkg::EIF_SRC_DT;
            end
        end
    end

    // Nothing is forwarded before the reset entry finishes, so no interrupt
    // can be taken before the program counter has been loaded.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_reg <= eif_pkg::EIF_SRC_NONE;
        end else if (running) begin
            src_reg <= src_next;
        end else begin
            src_reg <= eif_pkg::EIF_SRC_NONE;
        end
    end

    assign nmi_req_out    = (src_reg == eif_pkg::EIF_SRC_NMI);
    assign irq_req_out    = (src_reg != eif_pkg::EIF_SRC_NONE) && !nmi_req_out && !mask_reg;
    assign irq_source_out = src_reg;
    assign mask_bit_out   = mask_reg;

    // ------------------------------------------------------------------------
    // Interrupt mask bit
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_reg <= 1'b1;
        end else if (state_reg == eif_pkg::EIF_ST_MASK) begin
            mask_reg <= 1'b1; // R6
        end else if (cpu_accept_in && running && src_reg != eif_pkg::EIF_SRC_NONE) begin
            mask_reg <= 1'b1; // R12 R18
        end else if (wr_at(`EIF_OFS_CCR)) begin
            mask_reg <= wbyte[`EIF_BIT_MASK];
        end
    end

    // ------------------------------------------------------------------------
    // Reset exception sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg    <= eif_pkg::EIF_ST_MASK; // R4
            vec_rd_out   <= 1'b0;
            vec_addr_out <= `EIF_VEC_ADDR_HI;
            vec_hi_reg   <= 8'h00;
            pc_out       <= 16'h0000;
            pc_valid_out <= 1'b0;
        end else begin
            case (state_reg)
                eif_pkg::EIF_ST_MASK: begin
                    state_reg    <= eif_pkg::EIF_ST_RD_HI;
                    vec_rd_out   <= 1'b1;
                    vec_addr_out <= `EIF_VEC_ADDR_HI; // R7
                end
                eif_pkg::EIF_ST_RD_HI: begin
                    state_reg    <= eif_pkg::EIF_ST_RD_LO;
                    vec_addr_out <= `EIF_VEC_ADDR_LO; // R7
                end
                eif_pkg::EIF_ST_RD_LO: begin
                    state_reg  <= eif_pkg::EIF_ST_LOAD;
                    vec_rd_out <= 1'b0;
                    vec_hi_reg <= vec_data_in;
                end
                eif_pkg::EIF_ST_LOAD: begin
                    state_reg    <= eif_pkg::EIF_ST_RUN;
                    pc_out       <= {vec_hi_reg, vec_data_in}; // R7
                    pc_valid_out <= 1'b1;
                end
                eif_pkg::EIF_ST_RUN: begin
                    state_reg <= eif_pkg::EIF_ST_RUN;
                end
                default: begin
                    state_reg <= eif_pkg::EIF_ST_MASK;
                end
            endcase
        end
    end

    assign halt_out = !running; // R4

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_wake_reserved_ones: assert property (dp_rd_reg && dp_addr_reg == `EIF_OFS_WAKE_FLAGS // R1
        |-> hrdata_out[7:6] == 2'b11) else $error("wake flag reserved bits not one");
    a_wake_flag_set: assert property (wake_set != 6'h00 |=> (wake_flag_reg // R2
        & $past(wake_set)) == $past(wake_set)) else $error("wake flag not set");
    a_wake_flag_clear: assert property (wr_at(`EIF_OFS_WAKE_FLAGS) && wake_set == 6'h00 // R3
        |=> (wake_flag_reg & ~$past(wbyte[5:0])) == 6'h00)
        else $error("wake flag not cleared");
    a_write_one_keeps: assert property (wr_at(`EIF_OFS_FLAG_A) // R22
        |=> (req_flag_reg & $past(req_flag_reg) & $past(wbyte[3:0]))
            == ($past(req_flag_reg) & $past(wbyte[3:0])))
        else $error("writing one disturbed a flag");
    // Anchored on the first fetch state, so the reset-release edge itself never starts it.
    a_reset_entry_seq: assert property (state_reg == eif_pkg::EIF_ST_RD_HI // R6
        |-> mask_reg && vec_rd_out && vec_addr_out == `EIF_VEC_ADDR_HI
        ##1 vec_rd_out && vec_addr_out == `EIF_VEC_ADDR_LO ##2 pc_valid_out)
        else $error("reset entry sequence wrong");
    a_vector_load: assert property ($rose(pc_valid_out) // R7
        |-> pc_out == {$past(vec_data_in, 2), $past(vec_data_in)})
        else $error("vector not loaded into pc");
    a_nmi_ignores_mask: assert property (nmi_pend_reg && running && mask_reg // R9
        |=> nmi_req_out) else $error("nmi blocked by mask");
    a_req_needs_enable: assert property (irq_source_out == eif_pkg::EIF_SRC_REQ1 // R13
        |-> $past(enable_reg_a[1])) else $error("request forwarded while disabled");
    a_wake_common_gate: assert property (!enable_reg_a[`EIF_BIT_WAKE_EN] // R16
        && !$past(enable_reg_a[`EIF_BIT_WAKE_EN]) |-> src_reg != eif_pkg::EIF_SRC_WAKE)
        else $error("wake request passed common enable");
    a_accept_sets_mask: assert property (cpu_accept_in && irq_req_out |=> mask_reg) // R12
        else $error("accept did not set mask");
    a_periph_masked: assert property (!enable_reg_a[`EIF_BIT_TIMER] // R19
        && !$past(enable_reg_a[`EIF_BIT_TIMER]) |-> src_reg != eif_pkg::EIF_SRC_TIMER)
        else $error("timer request passed disabled enable");

    c_reset_done: cover property ($rose(pc_valid_out));
    c_wake_request: cover property (src_reg == eif_pkg::EIF_SRC_WAKE && irq_req_out);
    c_nmi_accept: cover property (accept_nmi);
    c_set_beats_clear: cover property (wr_at(`EIF_OFS_WAKE_FLAGS) && wake_set != 6'h00);

endmodule

/* test/eif_vec_model.sv */
// Vector memory model that the reset entry reads the start address from.
// Assumes a read strobe and an address registered on the same clock.
`timescale 1ns/10ps
module eif_vec_model #(
    parameter logic [7:0] HI_BYTE = 8'h12,
    parameter logic [7:0] LO_BYTE = 8'h34
) (
    input  wire logic        sys_clk_in,
    input  wire logic        vec_rd_in,
    input  wire logic [15:0] vec_addr_in,
    output logic      [7:0]  vec_data_out = 8'hA5
);
    // Outside a read the data toggles, so a stale byte is never mistaken.
    always @(posedge sys_clk_in) begin
        if (vec_rd_in)
            vec_data_out <= vec_addr_in[0] ? LO_BYTE : HI_BYTE;
        else
            vec_data_out <= ~vec_data_out;
    end
endmodule

/* test/eif_ctrl_tb.sv */
// Testbench of the interrupt controller: register table, pin edges, accept
// and reset entry. Assumes the vector model answers the reset fetch.
`timescale 1ns/10ps
`include "eif_ctrl_map.svh"
module eif_ctrl_tb;
    typedef struct packed {logic w; logic [8:0] a; logic [7:0] d, e;} eif_row_t;
    logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwr = 1'b0, nmi = 1'b1;
    logic        acc = 1'b0, tmr = 1'b0, dtr = 1'b0, rdy, resp, nreq, irq, mask, halt, vrd, pcv;
    logic [31:0] ha = 32'h0, hwd = 32'h0, q, hrd;
    logic [1:0]  htr = 2'h0;
    logic [3:0]  req = 4'hF, src;
    logic [5:0]  wk = 6'h3F;
    logic [7:0]  vd;
    logic [15:0] va, pc;
    int          fails = 0, checks = 0;
    eif_row_t rows [0:13] = '{
        '{1'b0, {1'b0, `EIF_OFS_WAKE_FLAGS}, 8'h00, 8'hC0},
        '{1'b0, {1'b0, `EIF_OFS_ENABLE_A}, 8'h00, 8'h10},
        '{1'b0, {1'b0, `EIF_OFS_FLAG_A}, 8'h00, 8'h30},
        '{1'b0, {1'b0, `EIF_OFS_CCR}, 8'h00, 8'h80},
        '{1'b1, {1'b0, `EIF_OFS_EDGE_A}, 8'h85, 8'h85},
        '{1'b1, {1'b0, `EIF_OFS_EDGE_B}, 8'h2A, 8'h2A},
        '{1'b1, {1'b0, `EIF_OFS_PMODE_A}, 8'h0F, 8'h0F},
        '{1'b1, {1'b0, `EIF_OFS_PMODE_B}, 8'h3F, 8'h3F},
        '{1'b1, {1'b0, `EIF_OFS_ENABLE_A}, 8'hEF, 8'hFF},
        '{1'b1, {1'b0, `EIF_OFS_ENABLE_A}, 8'h00, 8'h10},
        '{1'b1, {1'b0, `EIF_OFS_WAKE_FLAGS}, 8'h3F, 8'hC0},
        '{1'b1, {1'b0, `EIF_OFS_FLAG_A}, 8'hCF, 8'h30},
        '{1'b1, 9'h100, 8'hFF, 8'h00},
        '{1'b1, {1'b0, `EIF_OFS_CCR}, 8'h00, 8'h00}};

    eif_ctrl i_eif_ctrl (.sys_clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(ha),
        .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(rdy),
        .hrdata_out(hrd), .hreadyout_out(rdy), .hresp_out(resp), .nmi_pin_in(nmi),
        .req_pin_in(req), .wake_pin_in(wk), .timer_overflow_in(tmr),
        .direct_transition_in(dtr), .cpu_accept_in(acc), .nmi_req_out(nreq),
        .irq_req_out(irq), .irq_source_out(src), .mask_bit_out(mask), .halt_out(halt),
        .vec_rd_out(vrd), .vec_addr_out(va), .vec_data_in(vd), .pc_out(pc), .pc_valid_out(pcv));
    eif_vec_model i_eif_vec_model (.sys_clk_in(clk), .vec_rd_in(vrd), .vec_addr_in(va),
        .vec_data_out(vd));

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // The master waits on ready itself; no latency is assumed.
    task automatic bus(logic w, logic [8:0] a, logic [7:0] d);
        hsel <= 1'b1;
        htr <= 2'h2;
        ha <= {23'h0, a};
        hwr <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        htr <= 2'h0;
        hwd <= {24'h0, d};
        do @(posedge clk); while (rdy !== 1'b1);
        q = hrd;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        bus(1'b0, {1'b0, a}, 8'h00);
        chk("reg", {24'h0, e}, q);
    endtask
    task automatic pulse_accept;
        acc <= 1'b1;
        @(posedge clk);
        acc <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rst_entry(int n);
        rstn <= 1'b0;
        repeat (n) @(posedge clk);
        chk("halt", 1, {31'h0, halt});
        chk("pcv", 0, {31'h0, pcv});
        rstn <= 1'b1;
        for (int i = 0; i < 20 && pcv !== 1'b1; i++) @(posedge clk);
        chk("mask", 1, {31'h0, mask});
        chk("pc", 32'h1234, {16'h0, pc});
        bus(1'b0, {1'b0, `EIF_OFS_STATUS}, 8'h00);
        chk("status", 32'h0001_1234, q);
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial forever #2 clk = ~clk;
    initial begin
        #20000;
        fails++;
        summarize;
    end
    initial begin
        rst_entry(4);
        foreach (rows[i]) begin
            if (rows[i].w)
                bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            chk("row", {24'h0, rows[i].e}, q);
        end
        bus(1'b1, {1'b0, `EIF_OFS_EDGE_B}, 8'h00);
        bus(1'b1, {1'b0, `EIF_OFS_ENABLE_A}, 8'h20);
        wk <= 6'h37;
        repeat (8) @(posedge clk);
        chk("irq", 1, {31'h0, irq});
        chk("src", 6, {28'h0, src});
        rd(`EIF_OFS_WAKE_FLAGS, 8'hC8);
        bus(1'b1, {1'b0, `EIF_OFS_CCR}, 8'h80);
        bus(1'b1, {1'b0, `EIF_OFS_WAKE_FLAGS}, 8'hF7);
        rd(`EIF_OFS_WAKE_FLAGS, 8'hC0);
        bus(1'b1, {1'b0, `EIF_OFS_EDGE_A}, 8'h02);
        bus(1'b1, {1'b0, `EIF_OFS_ENABLE_A}, 8'h22);
        bus(1'b1, {1'b0, `EIF_OFS_CCR}, 8'h00);
        repeat (3) @(posedge clk);
        chk("irq", 0, {31'h0, irq});
        req <= 4'hD;
        repeat (8) @(posedge clk);
        rd(`EIF_OFS_FLAG_A, 8'h30);
        req <= 4'hF;
        repeat (8) @(posedge clk);
        chk("src", 3, {28'h0, src});
        rd(`EIF_OFS_FLAG_A, 8'h32);
        pulse_accept;
        chk("mask", 1, {31'h0, mask});
        chk("irq", 0, {31'h0, irq});
        nmi <= 1'b0;
        repeat (8) @(posedge clk);
        chk("nmi", 1, {31'h0, nreq});
        pulse_accept;
        chk("nmi", 0, {31'h0, nreq});
        tmr <= 1'b1;
        dtr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        dtr <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`EIF_OFS_FLAG_A, 8'hF2);
        nmi <= 1'b1;
        wk <= 6'h3F;
        rst_entry(10);
        rd(`EIF_OFS_FLAG_A, 8'h30);
        summarize;
    end
endmodule
